// ===== rtl/spss_pkg.sv
// Package for the system power state sequencer
package spss_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned RTC_HZ = 32768;
   // Delays in microseconds, figures as specified
   localparam int unsigned PGOOD_US = 3000;
   localparam int unsigned PGOOD_FIRST_US = 7800;
   localparam int unsigned OSC_US = 10000;
   localparam int unsigned OSC_FIRST_US = 31250;
   localparam int unsigned XTAL_MAX_US = 3000000;
   // Least times round up, in RTC ticks
   localparam int unsigned PGOOD_TICKS = (PGOOD_US * RTC_HZ + 999999) / 1000000;
   localparam int unsigned PGOOD_FIRST_TICKS = (PGOOD_FIRST_US * RTC_HZ + 999999) / 1000000;
   localparam int unsigned OSC_TICKS = (OSC_US * RTC_HZ + 999999) / 1000000;
   localparam int unsigned OSC_FIRST_TICKS = (OSC_FIRST_US * RTC_HZ + 999999) / 1000000;
   localparam int unsigned XTAL_MAX_TICKS = (XTAL_MAX_US / 1000000) * RTC_HZ;
   // Fractional divider from main clock to RTC tick
   localparam int unsigned RTC_ACC_W = 16;
   localparam logic [RTC_ACC_W:0] RTC_ACC_STEP = 17'(RTC_HZ / 256);
   localparam logic [RTC_ACC_W:0] RTC_ACC_MOD = 17'(CLK_HZ / 256);
   localparam int unsigned TICK_W = 17;
   localparam logic [TICK_W-1:0] TICK_ZERO = 17'h00000;
   localparam logic [TICK_W-1:0] TICK_ONE = 17'h00001;

   typedef enum logic [3:0] {
      SPSS_FIRST_XTAL,
      SPSS_STANDBY,
      SPSS_PGOOD_WAIT,
      SPSS_SLOW_RUN,
      SPSS_CONFIG_UP,
      SPSS_POWER_ON,
      SPSS_DEEP_SLEEP,
      SPSS_DEEP_WAKE,
      SPSS_CONFIG_DOWN,
      SPSS_ISOLATE,
      SPSS_SUPPLY_OFF
   } spss_state_type;

   typedef struct packed {
      logic net_clk_en;
      logic net_clk_fast;
      logic app_clk_en;
      logic main_osc_en;
   } spss_clk_type;

   typedef struct packed {
      logic supply_enable;
      logic rtc_isolate;
      logic net_reset;
      logic app_reset;
   } spss_pwr_type;
endpackage

// ===== rtl/spss_top.sv
// System power state sequencer: standby, wakeup, configuration and sleep control
`timescale 1ns/1ps
module spss_top #(
   // Tick step; raising it to the modulus gives one tick per clock for short runs
   parameter logic [spss_pkg::RTC_ACC_W:0] RTC_STEP = spss_pkg::RTC_ACC_STEP
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic xtal_ok_i,
   input wire logic wake_input_one_i,
   input wire logic wake_input_two_i,
   input wire logic wake_pol_one_i,
   input wire logic wake_pol_two_i,
   input wire logic timer_wake_i,
   input wire logic short_delays_i,
   input wire logic module_reset_pin_n_i,
   input wire logic config_done_i,
   input wire logic standby_req_i,
   input wire logic fw_update_i,
   input wire logic net_sleep_req_i,
   input wire logic app_sleep_req_i,
   input wire logic net_deep_req_i,
   input wire logic app_deep_req_i,
   input wire logic net_irq_i,
   input wire logic app_irq_i,
   output logic supply_enable_out_o,
   output logic core_regulator_enable_o,
   output logic rtc_isolate_o,
   output logic module_reset_pin_n_o,
   output logic module_reset_pin_n_oe_o,
   output logic net_reset_o,
   output logic app_reset_o,
   output logic net_clk_en_o,
   output logic net_clk_fast_o,
   output logic app_clk_en_o,
   output logic main_osc_en_o,
   output logic first_plug_o,
   output spss_pkg::spss_state_type state_o
);
   logic rst_s1_q;
   logic rst_n;
   logic [6:0] sync1_q;
   logic [6:0] sync2_q;
   logic wake1_prev_q;
   logic wake2_prev_q;
   logic timer_prev_q;
   logic wake_hit;
   logic [spss_pkg::RTC_ACC_W:0] acc_q;
   logic rtc_tick;
   logic [spss_pkg::TICK_W-1:0] cnt_q;
   logic cnt_load;
   logic [spss_pkg::TICK_W-1:0] cnt_load_val;
   logic cnt_done;
   logic first_plug_q;
   logic fw_hold_q;
   logic irq_net_s;
   logic irq_app_s;
   logic reset_pin_in_s;
   logic net_sleep_q;
   logic app_sleep_q;
   spss_pkg::spss_state_type state_q;
   spss_pkg::spss_state_type state_d;
   spss_pkg::spss_pwr_type pwr_q;
   spss_pkg::spss_pwr_type pwr_d;
   spss_pkg::spss_clk_type clk_q;
   spss_pkg::spss_clk_type clk_d;

   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {module_reset_pin_n_i, app_irq_i, net_irq_i, xtal_ok_i, timer_wake_i,
                     wake_input_two_i, wake_input_one_i};
         sync2_q <= sync1_q;
      end
   end

   assign irq_net_s = sync2_q[4];
   assign irq_app_s = sync2_q[5];
   assign reset_pin_in_s = sync2_q[6];

   // Only edges are kept; the raw level never leaves this block
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         wake1_prev_q <= 1'b0;
         wake2_prev_q <= 1'b0;
         timer_prev_q <= 1'b0;
      end else begin
         wake1_prev_q <= sync2_q[0];
         wake2_prev_q <= sync2_q[1];
         timer_prev_q <= sync2_q[2];
      end
   end

   function automatic logic edge_of(input logic now, input logic prev, input logic rising);
      edge_of = rising ? (now & ~prev) : (~now & prev);
   endfunction

   assign wake_hit = (sync2_q[2] & ~timer_prev_q) | edge_of(sync2_q[0], wake1_prev_q, wake_pol_one_i)
                   | edge_of(sync2_q[1], wake2_prev_q, wake_pol_two_i);

   // Fractional accumulator makes one 32.768 kHz tick enable
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
      end else if (acc_q + RTC_STEP >= spss_pkg::RTC_ACC_MOD) begin
         acc_q <= acc_q + RTC_STEP - spss_pkg::RTC_ACC_MOD;
      end else begin
         acc_q <= acc_q + RTC_STEP;
      end
   end
   assign rtc_tick = (acc_q + RTC_STEP >= spss_pkg::RTC_ACC_MOD);

   // Delay counter in RTC ticks
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= spss_pkg::TICK_ZERO;
      end else if (cnt_load) begin
         cnt_q <= cnt_load_val;
      end else if (rtc_tick && cnt_q != spss_pkg::TICK_ZERO) begin
         cnt_q <= cnt_q - spss_pkg::TICK_ONE;
      end
   end
   assign cnt_done = (cnt_q == spss_pkg::TICK_ZERO);

   // First plug marker lasts until software shortens the delays
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         first_plug_q <= 1'b1;
      end else if (short_delays_i) begin
         first_plug_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         fw_hold_q <= 1'b0;
      end else if (state_q == spss_pkg::SPSS_POWER_ON && fw_update_i) begin
         fw_hold_q <= 1'b1;
      end else if (state_q != spss_pkg::SPSS_CONFIG_DOWN) begin
         fw_hold_q <= 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_load = 1'b0;
      cnt_load_val = spss_pkg::TICK_ZERO;
      unique case (state_q)
         spss_pkg::SPSS_FIRST_XTAL: begin
            // Wait for the crystal itself; no timeout releases the request early
            if (sync2_q[3]) begin
               state_d = spss_pkg::SPSS_PGOOD_WAIT;
               cnt_load = 1'b1;
               cnt_load_val = spss_pkg::TICK_W'(spss_pkg::PGOOD_FIRST_TICKS);
            end
         end
         spss_pkg::SPSS_STANDBY: begin
            if (wake_hit) begin
               state_d = spss_pkg::SPSS_PGOOD_WAIT;
               cnt_load = 1'b1;
               cnt_load_val = first_plug_q ? spss_pkg::TICK_W'(spss_pkg::PGOOD_FIRST_TICKS)
                                           : spss_pkg::TICK_W'(spss_pkg::PGOOD_TICKS);
            end
         end
         spss_pkg::SPSS_PGOOD_WAIT: begin
            if (cnt_done) begin
               state_d = spss_pkg::SPSS_SLOW_RUN;
               cnt_load = 1'b1;
               cnt_load_val = first_plug_q ? spss_pkg::TICK_W'(spss_pkg::OSC_FIRST_TICKS)
                                           : spss_pkg::TICK_W'(spss_pkg::OSC_TICKS);
            end
         end
         spss_pkg::SPSS_SLOW_RUN: begin
            if (cnt_done) begin
               state_d = spss_pkg::SPSS_CONFIG_UP;
            end
         end
         spss_pkg::SPSS_CONFIG_UP: begin
            if (config_done_i) begin
               state_d = spss_pkg::SPSS_POWER_ON;
            end
         end
         spss_pkg::SPSS_POWER_ON: begin
            if (standby_req_i || fw_update_i) begin
               state_d = spss_pkg::SPSS_CONFIG_DOWN;
            end else if (net_deep_req_i && app_deep_req_i) begin
               state_d = spss_pkg::SPSS_DEEP_SLEEP;
            end
         end
         spss_pkg::SPSS_DEEP_SLEEP: begin
            if (irq_net_s || irq_app_s) begin
               state_d = spss_pkg::SPSS_DEEP_WAKE;
               cnt_load = 1'b1;
               cnt_load_val = spss_pkg::TICK_W'(spss_pkg::OSC_TICKS);
            end
         end
         spss_pkg::SPSS_DEEP_WAKE: begin
            if (cnt_done) begin
               state_d = spss_pkg::SPSS_POWER_ON;
            end
         end
         spss_pkg::SPSS_CONFIG_DOWN: begin
            if (config_done_i) begin
               state_d = fw_hold_q ? spss_pkg::SPSS_POWER_ON : spss_pkg::SPSS_ISOLATE;
            end
         end
         spss_pkg::SPSS_ISOLATE: begin
            state_d = spss_pkg::SPSS_SUPPLY_OFF;
         end
         spss_pkg::SPSS_SUPPLY_OFF: begin
            state_d = spss_pkg::SPSS_STANDBY;
         end
         default: begin
            state_d = spss_pkg::SPSS_STANDBY;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= spss_pkg::SPSS_FIRST_XTAL;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      pwr_d.supply_enable = 1'b1;
      pwr_d.rtc_isolate = 1'b0;
      pwr_d.net_reset = 1'b0;
      pwr_d.app_reset = 1'b0;
      unique case (state_d)
         spss_pkg::SPSS_FIRST_XTAL, spss_pkg::SPSS_STANDBY, spss_pkg::SPSS_SUPPLY_OFF: begin
            pwr_d.supply_enable = 1'b0;
            pwr_d.rtc_isolate = 1'b1;
            pwr_d.net_reset = 1'b1;
            pwr_d.app_reset = 1'b1;
         end
         spss_pkg::SPSS_PGOOD_WAIT, spss_pkg::SPSS_ISOLATE: begin
            pwr_d.rtc_isolate = 1'b1;
            pwr_d.net_reset = 1'b1;
            pwr_d.app_reset = 1'b1;
         end
         spss_pkg::SPSS_SLOW_RUN, spss_pkg::SPSS_CONFIG_UP, spss_pkg::SPSS_CONFIG_DOWN: begin
            pwr_d.app_reset = 1'b1;
         end
         default: begin
            pwr_d.app_reset = 1'b0;
         end
      endcase
   end

   // Power outputs decoded from the next state and registered so they change with state_o
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= '{supply_enable: 1'b0, rtc_isolate: 1'b1, net_reset: 1'b1, app_reset: 1'b1};
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Per-processor light sleep; a synchronised interrupt clears the sleep flag on the next clock
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         net_sleep_q <= 1'b0;
         app_sleep_q <= 1'b0;
      end else begin
         net_sleep_q <= net_sleep_req_i && !irq_net_s && state_q == spss_pkg::SPSS_POWER_ON;
         app_sleep_q <= app_sleep_req_i && !irq_app_s && state_q == spss_pkg::SPSS_POWER_ON;
      end
   end

   always_comb begin
      clk_d.main_osc_en = 1'b1;
      clk_d.net_clk_en = 1'b1;
      clk_d.net_clk_fast = 1'b1;
      clk_d.app_clk_en = 1'b1;
      // Decoded from the next state so clocks line up with state_o
      unique case (state_d)
         spss_pkg::SPSS_POWER_ON: begin
            clk_d.net_clk_en = !net_sleep_q;
            clk_d.app_clk_en = !app_sleep_q;
         end
         spss_pkg::SPSS_SLOW_RUN: begin
            clk_d.net_clk_fast = 1'b0;
            clk_d.app_clk_en = 1'b0;
         end
         spss_pkg::SPSS_DEEP_SLEEP, spss_pkg::SPSS_DEEP_WAKE: begin
            clk_d.main_osc_en = (state_d == spss_pkg::SPSS_DEEP_WAKE);
            clk_d.net_clk_en = 1'b0;
            clk_d.app_clk_en = 1'b0;
         end
         spss_pkg::SPSS_CONFIG_UP, spss_pkg::SPSS_CONFIG_DOWN: begin
            clk_d.app_clk_en = 1'b0;
         end
         default: begin
            clk_d = '0;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_q <= '0;
      end else begin
         clk_q <= clk_d;
      end
   end

   assign supply_enable_out_o = pwr_q.supply_enable;
   assign core_regulator_enable_o = pwr_q.supply_enable;
   assign rtc_isolate_o = pwr_q.rtc_isolate;
   // Open drain: enable low means the pin is pulled low
   assign module_reset_pin_n_o = 1'b0;
   assign module_reset_pin_n_oe_o = !pwr_q.net_reset;
   assign net_reset_o = pwr_q.net_reset | !reset_pin_in_s;
   assign app_reset_o = pwr_q.app_reset | !reset_pin_in_s;
   assign net_clk_en_o = clk_q.net_clk_en;
   assign net_clk_fast_o = clk_q.net_clk_fast;
   assign app_clk_en_o = clk_q.app_clk_en;
   assign main_osc_en_o = clk_q.main_osc_en;
   assign first_plug_o = first_plug_q;
   assign state_o = state_q;
endmodule // spss_top

// ===== verif/spss_top_asserts.sv
// Assertions for the system power state sequencer
`timescale 1ns/1ps
module spss_top_asserts #(
   parameter logic [spss_pkg::RTC_ACC_W:0] RTC_STEP = spss_pkg::RTC_ACC_STEP
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic net_irq_i,
   input wire logic supply_enable_out_o,
   input wire logic core_regulator_enable_o,
   input wire logic rtc_isolate_o,
   input wire logic module_reset_pin_n_oe_o,
   input wire logic net_reset_o,
   input wire logic app_reset_o,
   input wire logic net_clk_en_o,
   input wire logic net_clk_fast_o,
   input wire logic app_clk_en_o,
   input wire logic main_osc_en_o,
   input wire spss_pkg::spss_state_type state_o
);
   // Slack of two RTC ticks below 3 ms and 10 ms
   localparam int CYC_PER_TICK = int'(spss_pkg::RTC_ACC_MOD / RTC_STEP);
   localparam int PG_MIN = (int'(spss_pkg::PGOOD_TICKS) - 2) * CYC_PER_TICK;
   localparam int OSC_MIN = (int'(spss_pkg::OSC_TICKS) - 2) * CYC_PER_TICK;
   logic [31:0] pg_cnt_q;
   logic [31:0] sl_cnt_q;
   logic [31:0] dw_cnt_q;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pg_cnt_q <= 32'h0;
         sl_cnt_q <= 32'h0;
         dw_cnt_q <= 32'h0;
      end else begin
         pg_cnt_q <= (state_o == spss_pkg::SPSS_PGOOD_WAIT) ? pg_cnt_q + 32'h1 : 32'h0;
         sl_cnt_q <= (state_o == spss_pkg::SPSS_SLOW_RUN) ? sl_cnt_q + 32'h1 : 32'h0;
         dw_cnt_q <= (state_o == spss_pkg::SPSS_DEEP_WAKE) ? dw_cnt_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence pg_end;
      state_o == spss_pkg::SPSS_PGOOD_WAIT ##1 state_o == spss_pkg::SPSS_SLOW_RUN;
   endsequence
   sequence sl_end;
      state_o == spss_pkg::SPSS_SLOW_RUN ##1 state_o == spss_pkg::SPSS_CONFIG_UP;
   endsequence
   sequence dw_end;
      state_o == spss_pkg::SPSS_DEEP_WAKE ##1 state_o == spss_pkg::SPSS_POWER_ON;
   endsequence
   standby_off_a: assert property (state_o == spss_pkg::SPSS_STANDBY |->
      !supply_enable_out_o && !core_regulator_enable_o && rtc_isolate_o) else $error("standby outputs wrong");
   drop_order_a: assert property ($fell(supply_enable_out_o) |->
      $past(rtc_isolate_o) && $past(net_reset_o) && $past(app_reset_o)) else $error("supply dropped early");
   wake_reset_a: assert property ($rose(supply_enable_out_o) |->
      net_reset_o && app_reset_o && rtc_isolate_o) else $error("wake without reset");
   pgood_time_a: assert property (pg_end |->
      pg_cnt_q >= PG_MIN && !rtc_isolate_o && module_reset_pin_n_oe_o) else $error("power good too soon");
   slow_time_a: assert property (sl_end |-> sl_cnt_q >= OSC_MIN && net_clk_fast_o)
      else $error("fast clock too soon");
   app_held_a: assert property (state_o == spss_pkg::SPSS_CONFIG_UP |-> app_reset_o)
      else $error("app released in config");
   light_wake_a: assert property ($rose(net_irq_i) && state_o == spss_pkg::SPSS_POWER_ON |->
      ##[1:6] net_clk_en_o) else $error("sleep exit slow");
   osc_on_a: assert property (state_o == spss_pkg::SPSS_POWER_ON |-> main_osc_en_o)
      else $error("osc off in power on");
   deep_hold_a: assert property (state_o == spss_pkg::SPSS_DEEP_SLEEP |->
      !main_osc_en_o && supply_enable_out_o && !net_clk_en_o && !app_clk_en_o) else $error("deep sleep wrong");
   deep_time_a: assert property (dw_end |-> dw_cnt_q >= OSC_MIN)
      else $error("deep wake too soon");
   first_pin_a: assert property (state_o == spss_pkg::SPSS_FIRST_XTAL |-> !module_reset_pin_n_oe_o)
      else $error("pin released early");
endmodule // spss_top_asserts
bind spss_top spss_top_asserts #(.RTC_STEP(RTC_STEP)) spss_top_asserts_inst (.mclk_i, .rst_n_i, .net_irq_i,
   .supply_enable_out_o,
   .core_regulator_enable_o, .rtc_isolate_o, .module_reset_pin_n_oe_o, .net_reset_o, .app_reset_o,
   .net_clk_en_o, .net_clk_fast_o, .app_clk_en_o, .main_osc_en_o, .state_o);

// ===== verif/spss_host_model.sv
// Host and board model: open-drain reset pin and wake pins
`timescale 1ns/1ps
module spss_host_model (
   input wire logic supply_i,
   input wire logic dev_oe_n_i,
   input wire logic host_pull_i,
   input wire logic wake_one_i,
   input wire logic wake_two_i,
   output logic reset_pin_n_o,
   output logic wake_one_o,
   output logic wake_two_o
);
   // Pull-up sits on the switched rail, so the pin sags in standby
   assign reset_pin_n_o = supply_i & dev_oe_n_i & ~host_pull_i;
   // Host wakes only through pins and never switches supplies
   assign wake_one_o = wake_one_i;
   assign wake_two_o = wake_two_i;
endmodule // spss_host_model

// ===== verif/testbench.sv
// Self-checking bench for the system power state sequencer
`timescale 1ns/1ps
module testbench;
   logic mclk_i, rst_n_i, xtal_ok_i, wake_input_one_i, wake_input_two_i, wake_pol_one_i, wake_pol_two_i;
   logic timer_wake_i, short_delays_i, module_reset_pin_n_i, config_done_i, standby_req_i, fw_update_i;
   logic net_sleep_req_i, app_sleep_req_i, net_deep_req_i, app_deep_req_i, net_irq_i, app_irq_i;
   logic supply_enable_out_o, core_regulator_enable_o, rtc_isolate_o, module_reset_pin_n_o;
   logic module_reset_pin_n_oe_o, net_reset_o, app_reset_o, net_clk_en_o, net_clk_fast_o, app_clk_en_o;
   logic main_osc_en_o, first_plug_o, host_pull, w1_drv, w2_drv;
   spss_pkg::spss_state_type state_o;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   // One RTC tick per clock keeps the run short; delays then equal tick counts
   spss_top #(.RTC_STEP(spss_pkg::RTC_ACC_MOD)) spss_top_inst (.*);
   spss_host_model spss_host_model_inst (.supply_i(supply_enable_out_o), .dev_oe_n_i(module_reset_pin_n_oe_o),
      .host_pull_i(host_pull), .wake_one_i(w1_drv), .wake_two_i(w2_drv), .reset_pin_n_o(module_reset_pin_n_i),
      .wake_one_o(wake_input_one_i), .wake_two_o(wake_input_two_i));
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   function automatic logic near(int n, int t);
      return (n + 3 >= t) && (n <= t + 3);
   endfunction
   task automatic wst(spss_pkg::spss_state_type s, int lim, output int n);
      n = 0;
      while (state_o !== s && n < lim) begin
         @(negedge mclk_i);
         n++;
      end
      chk("state", state_o, s);
   endtask
   task automatic pulse_done;
      @(posedge mclk_i) config_done_i <= 1'b1;
      @(posedge mclk_i) config_done_i <= 1'b0;
   endtask
   task automatic t_first;
      int n;
      repeat (20) @(negedge mclk_i);
      chk("xtal wait", state_o, spss_pkg::SPSS_FIRST_XTAL);
      chk("pin oe", module_reset_pin_n_oe_o, 1'b0);
      chk("pin level", module_reset_pin_n_o, 1'b0);
      chk("first plug", first_plug_o, 1'b1);
      chk("supply", supply_enable_out_o, 1'b0);
      @(posedge mclk_i) xtal_ok_i <= 1'b1;
      wst(spss_pkg::SPSS_PGOOD_WAIT, 200, n);
      repeat (3) @(negedge mclk_i);
      chk("supply", supply_enable_out_o, 1'b1);
      chk("net reset", net_reset_o, 1'b1);
      wst(spss_pkg::SPSS_SLOW_RUN, 2000, n);
      chk("first pgood", near(n, int'(spss_pkg::PGOOD_FIRST_TICKS) - 2), 1'b1);
      chk("isolate", rtc_isolate_o, 1'b0);
      chk("app reset", app_reset_o, 1'b1);
      chk("slow clk", net_clk_fast_o, 1'b0);
      // Released pin comes back through the two-flop synchroniser
      repeat (3) @(negedge mclk_i);
      chk("net reset", net_reset_o, 1'b0);
      wst(spss_pkg::SPSS_CONFIG_UP, 2000, n);
      chk("first osc", near(n, int'(spss_pkg::OSC_FIRST_TICKS) - 2), 1'b1);
      chk("fast clk", net_clk_fast_o, 1'b1);
      pulse_done();
      wst(spss_pkg::SPSS_POWER_ON, 20, n);
      chk("app reset", app_reset_o, 1'b0);
   endtask
   task automatic t_sleep;
      @(posedge mclk_i) net_sleep_req_i <= 1'b1;
      repeat (6) @(negedge mclk_i);
      chk("net gated", net_clk_en_o, 1'b0);
      chk("app clk", app_clk_en_o, 1'b1);
      chk("osc", main_osc_en_o, 1'b1);
      @(posedge mclk_i) net_irq_i <= 1'b1;
      repeat (6) @(negedge mclk_i);
      chk("net woke", net_clk_en_o, 1'b1);
      @(posedge mclk_i) net_sleep_req_i <= 1'b0;
      @(posedge mclk_i) net_irq_i <= 1'b0;
      @(posedge mclk_i) host_pull <= 1'b1;
      repeat (4) @(negedge mclk_i);
      chk("host reset net", net_reset_o, 1'b1);
      chk("host reset app", app_reset_o, 1'b1);
      @(posedge mclk_i) host_pull <= 1'b0;
      repeat (4) @(negedge mclk_i);
      chk("host release net", net_reset_o, 1'b0);
      chk("host release app", app_reset_o, 1'b0);
   endtask
   task automatic t_deep;
      int n;
      @(posedge mclk_i) net_deep_req_i <= 1'b1;
      repeat (8) @(negedge mclk_i);
      chk("one deep req", state_o, spss_pkg::SPSS_POWER_ON);
      @(posedge mclk_i) app_deep_req_i <= 1'b1;
      wst(spss_pkg::SPSS_DEEP_SLEEP, 20, n);
      chk("osc off", main_osc_en_o, 1'b0);
      chk("supply", supply_enable_out_o, 1'b1);
      @(posedge mclk_i) {net_deep_req_i, app_deep_req_i, net_irq_i} <= 3'h1;
      wst(spss_pkg::SPSS_DEEP_WAKE, 10, n);
      wst(spss_pkg::SPSS_POWER_ON, 2000, n);
      chk("deep wake", near(n, int'(spss_pkg::OSC_TICKS) + 1), 1'b1);
      chk("net clk", net_clk_en_o, 1'b1);
      @(posedge mclk_i) net_irq_i <= 1'b0;
   endtask
   task automatic t_standby;
      int n;
      @(posedge mclk_i) fw_update_i <= 1'b1;
      @(posedge mclk_i) fw_update_i <= 1'b0;
      wst(spss_pkg::SPSS_CONFIG_DOWN, 20, n);
      chk("fw app reset", app_reset_o, 1'b1);
      pulse_done();
      wst(spss_pkg::SPSS_POWER_ON, 20, n);
      chk("fw supply", supply_enable_out_o, 1'b1);
      @(posedge mclk_i) standby_req_i <= 1'b1;
      @(posedge mclk_i) standby_req_i <= 1'b0;
      wst(spss_pkg::SPSS_CONFIG_DOWN, 20, n);
      pulse_done();
      wst(spss_pkg::SPSS_ISOLATE, 20, n);
      chk("isolate", rtc_isolate_o, 1'b1);
      chk("supply", supply_enable_out_o, 1'b1);
      wst(spss_pkg::SPSS_STANDBY, 50, n);
      chk("supply", supply_enable_out_o, 1'b0);
      chk("core reg", core_regulator_enable_o, 1'b0);
      chk("isolate", rtc_isolate_o, 1'b1);
   endtask
   task automatic t_wake;
      int n;
      @(posedge mclk_i) short_delays_i <= 1'b1;
      @(posedge mclk_i) short_delays_i <= 1'b0;
      @(posedge mclk_i) w1_drv <= 1'b1;
      repeat (20) @(negedge mclk_i);
      chk("wrong edge", state_o, spss_pkg::SPSS_STANDBY);
      chk("first plug", first_plug_o, 1'b0);
      @(posedge mclk_i) w2_drv <= 1'b1;
      wst(spss_pkg::SPSS_PGOOD_WAIT, 20, n);
      wst(spss_pkg::SPSS_SLOW_RUN, 2000, n);
      chk("pgood", near(n, int'(spss_pkg::PGOOD_TICKS) + 1), 1'b1);
      chk("short", n < int'(spss_pkg::PGOOD_FIRST_TICKS), 1'b1);
      wst(spss_pkg::SPSS_CONFIG_UP, 2000, n);
      chk("osc", near(n, int'(spss_pkg::OSC_TICKS) + 1), 1'b1);
   endtask
   task automatic t_timer;
      int n;
      pulse_done();
      wst(spss_pkg::SPSS_POWER_ON, 20, n);
      @(posedge mclk_i) standby_req_i <= 1'b1;
      @(posedge mclk_i) standby_req_i <= 1'b0;
      wst(spss_pkg::SPSS_CONFIG_DOWN, 20, n);
      pulse_done();
      wst(spss_pkg::SPSS_STANDBY, 20, n);
      @(posedge mclk_i) timer_wake_i <= 1'b1;
      wst(spss_pkg::SPSS_PGOOD_WAIT, 20, n);
      chk("timer supply", supply_enable_out_o, 1'b1);
   endtask
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Whole run is a few thousand cycles with one RTC tick per clock
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 10000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      {rst_n_i, xtal_ok_i, wake_pol_one_i, timer_wake_i, short_delays_i, config_done_i, standby_req_i} = 7'h00;
      {fw_update_i, net_sleep_req_i, app_sleep_req_i, net_deep_req_i, app_deep_req_i, net_irq_i, app_irq_i} = 7'h00;
      {wake_pol_two_i, host_pull, w1_drv, w2_drv} = 4'h8;
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_first();
      t_sleep();
      t_deep();
      t_standby();
      t_wake();
      t_timer();
      stop_test();
   end
endmodule // testbench
